// ---- hw/cifl_pkg.sv ----
// Constants and carriers for the core interrupt flag logic
package cifl_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_CORE = 'h07;
    localparam int IDX_P2 = 'h10;
    localparam int IDX_ISTAT = 'h20;
    localparam int IDX_ICLR = 'h21;
    localparam int IDX_IEN = 'h22;
    localparam int IDX_CTRL = 'h23;
    localparam logic [11:0] A_CORE = 12'(IDX_CORE * 4);
    localparam logic [11:0] A_P2 = 12'(IDX_P2 * 4);
    localparam logic [11:0] A_ISTAT = 12'(IDX_ISTAT * 4);
    localparam logic [11:0] A_ICLR = 12'(IDX_ICLR * 4);
    localparam logic [11:0] A_IEN = 12'(IDX_IEN * 4);
    localparam logic [11:0] A_CTRL = 12'(IDX_CTRL * 4);
    localparam int C_SUM = 7;
    localparam int C_PINF = 6;
    localparam int C_TOVF = 5;
    localparam int C_EXTF = 4;
    localparam int C_PEN = 3;
    localparam int C_PINE = 2;
    localparam int C_TOVE = 1;
    localparam int C_EXTE = 0;
    localparam logic [7:0] CORE_RESET = 8'h00;
    localparam int P2_SER = 7;
    localparam int P2_BCL = 6;
    localparam int P2_CONV = 5;
    localparam int P2_CAP4 = 3;
    localparam int P2_CAP3 = 2;
    localparam int P2_TX = 1;
    localparam int P2_RX = 0;
    localparam logic [7:0] P2_RW_MASK = 8'hEC;
    localparam logic [7:0] P2_RESET = 8'h00;
    localparam int K_GDIS = 0;
    localparam int K_PINRISE = 1;
    localparam int K_EXTRISE = 2;
    localparam logic [2:0] CTRL_RESET = 3'h7;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_EXT = 8'h08;
    localparam logic [7:0] VEC_TOVF = 8'h10;
    localparam logic [7:0] VEC_PIN = 8'h18;
    localparam logic [7:0] VEC_PERI = 8'h20;
    localparam int SYNC_STAGES = 3;
    typedef struct packed {
        logic xferDone;
        logic startDone;
        logic stopDone;
        logic rstartDone;
        logic ackDone;
        logic startSeen;
        logic stopSeen;
    } cifl_serial_t;
    typedef struct packed {
        logic busCollision;
        logic convDone;
        logic capture4;
        logic capture3;
    } cifl_periph_t;
endpackage

// ---- hw/cifl_core.sv ----
// Core interrupt flag, enable and vectoring logic with APB registers
//
// Behaviour
// - Peripheral summary bit reads as OR of all peripheral flag bits.
// - Flags set on their event regardless of enables or global disable.
// - Enable cleared while enabled and its flag setting: vector to reset.
// - Pin edge flag sets on chosen edge, cleared when its vector taken.
// - Timer overflow flag sets on overflow, cleared when its vector taken.
// - Timer overflow enable gates the timer overflow request.
// - Serial flag sets on transfer or initiated condition done; software clears.
// - Interrupt wake-up shows its source in the flag registers.
// - Wake-up with interrupts enabled loads the interrupt vector.
// - Return from interrupt re-enables interrupts globally.
// - In I2C mode detected start and stop conditions set the serial flag.
`timescale 1ns/10ps
`default_nettype none
module cifl_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // APB slave
    input wire logic [cifl_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic timerOverflow,
    input wire logic timerClockPin,
    input wire logic externalEdgePin,
    input wire cifl_pkg::cifl_serial_t serialEvt,
    input wire logic i2cMode,
    input wire cifl_pkg::cifl_periph_t periphEvt,
    input wire logic secondChannelTxEmpty,
    input wire logic secondChannelRxFull,
    input wire logic [7:0] periphOneFlags,
    // CPU vectoring
    input wire logic vectorTaken,
    input wire logic returnFromInterrupt,
    output logic vectorRequest,
    output logic [7:0] vectorAddress,
    output logic resetVectorRequest,
    output logic wakeRequest,
    output logic irq
);
    logic [31:0] prdata_reg, rdMux;
    logic pready_reg, pslverr_reg, vreq_reg, rstv_reg, wake_reg, irq_reg;
    logic [7:0] core_reg, p2_reg, istat_reg, ien_reg, vaddr_reg, evt, core_next, p2_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [1:0] s1, s2, s3, stable, pinEdge, pinIn, riseSel;
    logic setupPh, wrAcc, hit, gdis, summary, serSet, periAny, resetEvt;
    logic [3:0] pend, enClr, flagEvt;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign vectorRequest = vreq_reg;
    assign vectorAddress = vaddr_reg;
    assign resetVectorRequest = rstv_reg;
    assign wakeRequest = wake_reg;
    assign irq = irq_reg;

    assign gdis = ctrl_reg[cifl_pkg::K_GDIS];
    assign setupPh = psel & ~penable;
    assign wrAcc = psel & penable & pready_reg & pwrite;

    // Pin inputs: three flops, level accepted when stages two and three agree
    assign pinIn = {externalEdgePin, timerClockPin};
    assign riseSel = {ctrl_reg[cifl_pkg::K_EXTRISE], ctrl_reg[cifl_pkg::K_PINRISE]};
    for (genvar i = 0; i < 2; i++) begin : g_pin
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                s1[i] <= 1'b0;
                s2[i] <= 1'b0;
                s3[i] <= 1'b0;
                stable[i] <= 1'b0;
            end else begin
                s1[i] <= pinIn[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    stable[i] <= s3[i];
                end
            end
        end
        // Selected edge only; polarity from the control register
        assign pinEdge[i] = (s2[i] == s3[i]) & (s3[i] != stable[i])
            & (s3[i] == riseSel[i]);
    end

    // Serial flag causes; start/stop detection only counts in I2C mode
    assign serSet = serialEvt.xferDone | serialEvt.startDone
        | serialEvt.stopDone | serialEvt.rstartDone | serialEvt.ackDone
        | (i2cMode & (serialEvt.startSeen | serialEvt.stopSeen));
    assign periAny = serSet | periphEvt.busCollision | periphEvt.convDone
        | periphEvt.capture4 | periphEvt.capture3;

    // Summary is unmasked: a disabled peripheral still shows here
    assign summary = |{p2_reg & cifl_pkg::P2_RW_MASK, secondChannelTxEmpty,
        secondChannelRxFull, periphOneFlags};

    assign pend = {summary & core_reg[cifl_pkg::C_PEN],
        core_reg[cifl_pkg::C_PINF] & core_reg[cifl_pkg::C_PINE],
        core_reg[cifl_pkg::C_TOVF] & core_reg[cifl_pkg::C_TOVE],
        core_reg[cifl_pkg::C_EXTF] & core_reg[cifl_pkg::C_EXTE]};

    // Enable dropped by software while interrupts are live
    always_comb begin
        enClr = 4'h0;
        if (wrAcc && paddr == cifl_pkg::A_CORE && !gdis) begin
            enClr = core_reg[3:0] & ~pwdata[3:0];
        end
    end
    assign flagEvt = {periAny, pinEdge[0], timerOverflow, pinEdge[1]};
    // Software guard against this is setting global disable first
    assign resetEvt = |(enClr & flagEvt);

    assign evt = {resetEvt, periphEvt.capture4 | periphEvt.capture3,
        periphEvt.convDone, periphEvt.busCollision, serSet,
        pinEdge[0], timerOverflow, pinEdge[1]};

    // Core register: hardware set wins over software and vector clears
    always_comb begin
        core_next = core_reg;
        if (wrAcc && paddr == cifl_pkg::A_CORE) begin
            core_next[6:0] = pwdata[6:0];
        end
        if (vectorTaken && vaddr_reg == cifl_pkg::VEC_PIN) begin
            core_next[cifl_pkg::C_PINF] = 1'b0;
        end
        if (vectorTaken && vaddr_reg == cifl_pkg::VEC_TOVF) begin
            core_next[cifl_pkg::C_TOVF] = 1'b0;
        end
        if (vectorTaken && vaddr_reg == cifl_pkg::VEC_EXT) begin
            core_next[cifl_pkg::C_EXTF] = 1'b0;
        end
        if (pinEdge[0]) begin
            core_next[cifl_pkg::C_PINF] = 1'b1;
        end
        if (timerOverflow) begin
            core_next[cifl_pkg::C_TOVF] = 1'b1;
        end
        if (pinEdge[1]) begin
            core_next[cifl_pkg::C_EXTF] = 1'b1;
        end
        core_next[cifl_pkg::C_SUM] = 1'b0;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            core_reg <= cifl_pkg::CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // Second peripheral flags; no hardware clear, only software
    always_comb begin
        p2_next = p2_reg;
        if (wrAcc && paddr == cifl_pkg::A_P2) begin
            p2_next = pwdata[7:0] & cifl_pkg::P2_RW_MASK;
        end
        if (serSet) begin
            p2_next[cifl_pkg::P2_SER] = 1'b1;
        end
        if (periphEvt.busCollision) begin
            p2_next[cifl_pkg::P2_BCL] = 1'b1;
        end
        if (periphEvt.convDone) begin
            p2_next[cifl_pkg::P2_CONV] = 1'b1;
        end
        if (periphEvt.capture4) begin
            p2_next[cifl_pkg::P2_CAP4] = 1'b1;
        end
        if (periphEvt.capture3) begin
            p2_next[cifl_pkg::P2_CAP3] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            p2_reg <= cifl_pkg::P2_RESET;
        end else begin
            p2_reg <= p2_next;
        end
    end

    // Global disable: vector entry sets it, return clears it
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wrAcc && paddr == cifl_pkg::A_CTRL) begin
            ctrl_next = pwdata[2:0];
        end
        if (returnFromInterrupt) begin
            ctrl_next[cifl_pkg::K_GDIS] = 1'b0;
        end
        if (vectorTaken) begin
            ctrl_next[cifl_pkg::K_GDIS] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= cifl_pkg::CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Vector request in fixed priority; dropped while a take is acknowledged
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vreq_reg <= 1'b0;
            vaddr_reg <= cifl_pkg::VEC_RESET;
            rstv_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            vreq_reg <= ~gdis & (|pend) & ~vectorTaken;
            wake_reg <= |pend;
            rstv_reg <= resetEvt;
            if (pend[0]) begin
                vaddr_reg <= cifl_pkg::VEC_EXT;
            end else if (pend[1]) begin
                vaddr_reg <= cifl_pkg::VEC_TOVF;
            end else if (pend[2]) begin
                vaddr_reg <= cifl_pkg::VEC_PIN;
            end else if (pend[3]) begin
                vaddr_reg <= cifl_pkg::VEC_PERI;
            end
        end
    end

    // Sticky event status; new events win over a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            istat_reg <= 8'h00;
            ien_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            if (wrAcc && paddr == cifl_pkg::A_ICLR) begin
                istat_reg <= (istat_reg & ~pwdata[7:0]) | evt;
            end else begin
                istat_reg <= istat_reg | evt;
            end
            if (wrAcc && paddr == cifl_pkg::A_IEN) begin
                ien_reg <= pwdata[7:0];
            end
            irq_reg <= |(istat_reg & ien_reg);
        end
    end

    // Read decode; write-only clear register reads zero
    always_comb begin
        rdMux = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == cifl_pkg::A_CORE) begin
            rdMux[7:0] = {summary, core_reg[6:0]};
        end else if (paddr == cifl_pkg::A_P2) begin
            rdMux[7:0] = (p2_reg & cifl_pkg::P2_RW_MASK)
                | {6'h00, secondChannelTxEmpty, secondChannelRxFull};
        end else if (paddr == cifl_pkg::A_ISTAT) begin
            rdMux[7:0] = istat_reg;
        end else if (paddr == cifl_pkg::A_ICLR) begin
            rdMux = 32'h0000_0000;
        end else if (paddr == cifl_pkg::A_IEN) begin
            rdMux[7:0] = ien_reg;
        end else if (paddr == cifl_pkg::A_CTRL) begin
            rdMux[2:0] = ctrl_reg;
        end else begin
            hit = 1'b0;
        end
    end

    // One wait-free access phase: answer prepared in the setup cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setupPh;
            pslverr_reg <= setupPh & ~hit;
            if (setupPh && !pwrite) begin
                prdata_reg <= rdMux;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_sum;
        pready_reg && !pwrite && paddr == cifl_pkg::A_CORE && !pslverr_reg
            |-> prdata_reg[cifl_pkg::C_SUM] == $past(summary);
    endproperty
    a_sum: assert property (p_sum) else $error("summary read wrong");
    property p_tovset;
        timerOverflow && !core_reg[cifl_pkg::C_TOVE] && gdis
            |=> core_reg[cifl_pkg::C_TOVF];
    endproperty
    a_tovset: assert property (p_tovset) else $error("flag not set");
    property p_rstv;
        resetEvt |=> rstv_reg ##1 !rstv_reg || $past(resetEvt);
    endproperty
    a_rstv: assert property (p_rstv) else $error("no reset vector");
    property p_pinclr;
        vectorTaken && vaddr_reg == cifl_pkg::VEC_PIN && !pinEdge[0]
            |=> !core_reg[cifl_pkg::C_PINF];
    endproperty
    a_pinclr: assert property (p_pinclr) else $error("pin flag kept");
    property p_tovclr;
        vectorTaken && vaddr_reg == cifl_pkg::VEC_TOVF && !timerOverflow
            |=> !core_reg[cifl_pkg::C_TOVF];
    endproperty
    a_tovclr: assert property (p_tovclr) else $error("timer flag kept");
    property p_tovgate;
        vreq_reg && vaddr_reg == cifl_pkg::VEC_TOVF
            |-> $past(core_reg[cifl_pkg::C_TOVE]);
    endproperty
    a_tovgate: assert property (p_tovgate) else $error("ungated timer");
    property p_serhold;
        p2_reg[cifl_pkg::P2_SER] && !(wrAcc && paddr == cifl_pkg::A_P2)
            |=> p2_reg[cifl_pkg::P2_SER];
    endproperty
    a_serhold: assert property (p_serhold) else $error("serial flag lost");

    property p_wake;
        |pend |=> wake_reg;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_vreq;
        !gdis && |pend && !vectorTaken |=> vreq_reg;
    endproperty
    a_vreq: assert property (p_vreq) else $error("no vector");

    property p_rfi;
        returnFromInterrupt && !vectorTaken |=> !gdis;
    endproperty
    a_rfi: assert property (p_rfi) else $error("still disabled");

    property p_i2c;
        i2cMode && serialEvt.startSeen ##1 !wrAcc
            |-> p2_reg[cifl_pkg::P2_SER];
    endproperty
    a_i2c: assert property (p_i2c) else $error("start not flagged");

    property p_bcl;
        periphEvt.busCollision |=> p2_reg[cifl_pkg::P2_BCL];
    endproperty
    a_bcl: assert property (p_bcl) else $error("collision lost");

    c_vec: cover property (vreq_reg ##1 vectorTaken);
    c_rst: cover property (rstv_reg);
    c_irq: cover property (irq_reg);
    c_pin: cover property (pinEdge[0] ##1 core_reg[cifl_pkg::C_PINF]);
endmodule
`default_nettype wire

// ---- sim/cifl_cpu_model.sv ----
// CPU vectoring model that answers the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module cifl_cpu_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // From the controller
    input wire logic vectorRequest,
    input wire logic [7:0] vectorAddress,
    input wire logic wakeRequest,
    // Bench control
    input wire logic [3:0] takeDelay,
    input wire logic retCmd,
    // To the controller and bench
    output logic vectorTaken,
    output logic returnFromInterrupt,
    output logic [7:0] lastVector,
    output logic lastWake,
    output logic [7:0] takeCount
);
    logic [3:0] waitCnt;

    // Slow takes leave the request standing several cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt <= 4'h0;
            vectorTaken <= 1'b0;
            lastVector <= 8'h00;
            lastWake <= 1'b0;
            takeCount <= 8'h00;
        end else begin
            vectorTaken <= 1'b0;
            if (vectorRequest && !vectorTaken) begin
                if (waitCnt >= takeDelay) begin
                    vectorTaken <= 1'b1;
                    lastVector <= vectorAddress;
                    lastWake <= wakeRequest;
                    takeCount <= takeCount + 8'h01;
                    waitCnt <= 4'h0;
                end else begin
                    waitCnt <= waitCnt + 4'h1;
                end
            end else begin
                waitCnt <= 4'h0;
            end
        end
    end

    // Return is issued only when the bench asks for it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            returnFromInterrupt <= 1'b0;
        end else begin
            returnFromInterrupt <= retCmd;
        end
    end
endmodule
`default_nettype wire

// ---- sim/core_interrupt_flag_logic_tb_top.sv ----
// Self-checking bench for the core interrupt flag logic
`timescale 1ns/10ps
`default_nettype none
module core_interrupt_flag_logic_tb_top;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic timerOverflow, timerClockPin, externalEdgePin, i2cMode, txEmpty, rxFull;
    logic vectorTaken, rfi, vectorRequest, resetVec, wake, irq, lastWake, retCmd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] periphOne, vecAddr, lastVector, takeCount;
    logic [3:0] takeDelay;
    cifl_pkg::cifl_serial_t serialEvt;
    cifl_pkg::cifl_periph_t periphEvt;
    int nMismatch, samplesChecked, nRstVec, cycles;
    logic [31:0] pexp [4] = '{32'h40, 32'h20, 32'h08, 32'h04};

    cifl_core i_dut (.mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timerOverflow(timerOverflow),
        .timerClockPin(timerClockPin), .externalEdgePin(externalEdgePin),
        .serialEvt(serialEvt), .i2cMode(i2cMode), .periphEvt(periphEvt),
        .secondChannelTxEmpty(txEmpty), .secondChannelRxFull(rxFull),
        .periphOneFlags(periphOne), .vectorTaken(vectorTaken),
        .returnFromInterrupt(rfi), .vectorRequest(vectorRequest),
        .vectorAddress(vecAddr), .resetVectorRequest(resetVec),
        .wakeRequest(wake), .irq(irq));

    cifl_cpu_model i_cpu (.mclk(mclk), .reset_n(reset_n), .vectorRequest(vectorRequest),
        .vectorAddress(vecAddr), .wakeRequest(wake), .takeDelay(takeDelay),
        .retCmd(retCmd), .vectorTaken(vectorTaken), .returnFromInterrupt(rfi),
        .lastVector(lastVector), .lastWake(lastWake), .takeCount(takeCount));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic testDone;
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Pulses are one cycle wide, so count them on every edge
    always @(posedge mclk) begin
        cycles++;
        if (resetVec === 1'b1) nRstVec++;
        if (cycles == 20000) begin
            nMismatch++;
            testDone();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Optional overflow pulse lands on the write's own edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        input logic ovf);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        timerOverflow <= ovf;
        do begin
            @(posedge mclk);
            timerOverflow <= 1'b0;
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(a, 1'b0, 32'h0, 1'b0);
        chk(name, rdv, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 1'b0);
    endtask

    task automatic fire(input logic ovf, input cifl_pkg::cifl_serial_t s,
        input cifl_pkg::cifl_periph_t p);
        @(posedge mclk);
        timerOverflow <= ovf;
        serialEvt <= s;
        periphEvt <= p;
        @(posedge mclk);
        timerOverflow <= 1'b0;
        serialEvt <= '0;
        periphEvt <= '0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic waitTake(input logic [7:0] n);
        int k;
        k = 0;
        while (takeCount !== n && k < 50) begin
            @(posedge mclk);
            k++;
        end
        chk("takeCount", {24'h0, takeCount}, {24'h0, n});
        repeat (2) @(posedge mclk);
    endtask

    task automatic ret;
        @(posedge mclk);
        retCmd <= 1'b1;
        @(posedge mclk);
        retCmd <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, timerOverflow, timerClockPin, externalEdgePin} = '0;
        {i2cMode, txEmpty, rxFull, retCmd} = '0;
        paddr = '0;
        pwdata = '0;
        periphOne = '0;
        serialEvt = '0;
        periphEvt = '0;
        takeDelay = 4'h5;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values, read-only status, unmapped word
        rd(cifl_pkg::A_CORE, 32'h00, "core reset");
        rd(cifl_pkg::A_CTRL, {29'h0, cifl_pkg::CTRL_RESET}, "ctrl reset");
        rd(cifl_pkg::A_P2, 32'h00, "p2 reset");
        rd(12'hFFC, 32'h00, "unmapped data");
        chk("unmapped err", {31'h0, err}, 32'h1);
        wr(cifl_pkg::A_ISTAT, 32'hFF);
        rd(cifl_pkg::A_ISTAT, 32'h00, "status ro");
        $display("test reset done");
        // Overflow while globally disabled, then irq and vectoring
        fire(1'b1, '0, '0);
        rd(cifl_pkg::A_CORE, 32'h20, "ovf flag");
        rd(cifl_pkg::A_ISTAT, 32'h02, "ovf status");
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(cifl_pkg::A_IEN, 32'h02);
        rd(cifl_pkg::A_IEN, 32'h02, "enable rw");
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(cifl_pkg::A_ICLR, 32'h02);
        rd(cifl_pkg::A_ISTAT, 32'h00, "status cleared");
        chk("irq off", {31'h0, irq}, 32'h0);
        rd(cifl_pkg::A_ICLR, 32'h00, "clear reads zero");
        wr(cifl_pkg::A_IEN, 32'h00);
        wr(cifl_pkg::A_CORE, 32'h22);
        wr(cifl_pkg::A_CTRL, 32'h06);
        waitTake(8'h01);
        chk("ovf vector", {24'h0, lastVector}, 32'h10);
        chk("wake at take", {31'h0, lastWake}, 32'h1);
        rd(cifl_pkg::A_CORE, 32'h02, "ovf auto clear");
        rd(cifl_pkg::A_CTRL, 32'h07, "disable on take");
        ret();
        rd(cifl_pkg::A_CTRL, 32'h06, "return enables");
        $display("test overflow done");
        // Overflow with its enable clear stays unvectored
        wr(cifl_pkg::A_CTRL, 32'h07);
        wr(cifl_pkg::A_CORE, 32'h00);
        wr(cifl_pkg::A_CTRL, 32'h06);
        fire(1'b1, '0, '0);
        repeat (4) @(posedge mclk);
        chk("no request", {31'h0, vectorRequest}, 32'h0);
        chk("no take", {24'h0, takeCount}, 32'h1);
        rd(cifl_pkg::A_CORE, 32'h20, "flag still set");
        wr(cifl_pkg::A_CORE, 32'h00);
        $display("test enable gate done");
        // Enable cleared in the cycle its flag sets
        wr(cifl_pkg::A_CORE, 32'h02);
        apb(cifl_pkg::A_CORE, 1'b1, 32'h00, 1'b1);
        repeat (2) @(posedge mclk);
        chk("reset vector", 32'(nRstVec), 32'h1);
        rd(cifl_pkg::A_CORE, 32'h20, "set beats clear");
        wr(cifl_pkg::A_CTRL, 32'h07);
        wr(cifl_pkg::A_CORE, 32'h00);
        $display("test reset vector done");
        // Every serial completion, bus conditions only in I2C mode
        for (int i = 0; i < 9; i++) begin
            i2cMode <= (i >= 7);
            fire(1'b0, 7'(1 << (i % 7)), '0);
            rd(cifl_pkg::A_P2, (i % 7 >= 2 || i >= 7) ? 32'h80 : 32'h0, "serial");
            rd(cifl_pkg::A_CORE, (i % 7 >= 2 || i >= 7) ? 32'h80 : 32'h0, "sum");
            wr(cifl_pkg::A_P2, 32'h00);
        end
        $display("test serial done");
        // Sticky peripheral flags and the unimplemented bit
        for (int j = 0; j < 4; j++) begin
            fire(1'b0, '0, 4'(8 >> j));
            rd(cifl_pkg::A_P2, pexp[j], "periph flag");
            wr(cifl_pkg::A_P2, 32'h00);
            rd(cifl_pkg::A_P2, 32'h00, "periph cleared");
        end
        wr(cifl_pkg::A_P2, 32'hFF);
        rd(cifl_pkg::A_P2, 32'hEC, "p2 write mask");
        wr(cifl_pkg::A_P2, 32'h00);
        $display("test periph done");
        // Buffer state flags and summary of the first group
        txEmpty <= 1'b1;
        rxFull <= 1'b1;
        wr(cifl_pkg::A_P2, 32'h00);
        rd(cifl_pkg::A_P2, 32'h03, "buffer flags");
        rd(cifl_pkg::A_CORE, 32'h80, "sum buffers");
        txEmpty <= 1'b0;
        rxFull <= 1'b0;
        periphOne <= 8'h10;
        rd(cifl_pkg::A_P2, 32'h00, "buffers follow");
        rd(cifl_pkg::A_CORE, 32'h80, "sum first group");
        periphOne <= 8'h00;
        rd(cifl_pkg::A_CORE, 32'h00, "sum idle");
        $display("test summary done");
        // Pin edges through the synchroniser, prompt take
        takeDelay <= 4'h0;
        wr(cifl_pkg::A_CORE, 32'h04);
        timerClockPin <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(cifl_pkg::A_CORE, 32'h44, "pin rising");
        wr(cifl_pkg::A_CTRL, 32'h06);
        waitTake(8'h02);
        chk("pin vector", {24'h0, lastVector}, 32'h18);
        rd(cifl_pkg::A_CORE, 32'h04, "pin auto clear");
        ret();
        wr(cifl_pkg::A_CTRL, 32'h07);
        wr(cifl_pkg::A_CORE, 32'h00);
        wr(cifl_pkg::A_CTRL, 32'h03);
        externalEdgePin <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(cifl_pkg::A_CORE, 32'h00, "ext wrong edge");
        externalEdgePin <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(cifl_pkg::A_CORE, 32'h10, "ext falling");
        wr(cifl_pkg::A_CORE, 32'h08);
        fire(1'b0, '0, 4'h8);
        wr(cifl_pkg::A_CTRL, 32'h02);
        waitTake(8'h03);
        chk("peri vector", {24'h0, lastVector}, 32'h20);
        $display("test pins done");
        testDone();
    end
endmodule
`default_nettype wire
